// >>> design/atx_host_power_control.sv
// Chosen here: the AHB-Lite slave port and the address map.
`include "atx_power_regs.svh"
`default_nettype none
module atx_host_power_control #(
	parameter logic [31:0] HOLD_SHORT_CYC = 32'(`HOLD_SHORT_MS * `CLK_KHZ),
	parameter logic [31:0] HOLD_LONG_CYC = 32'(`HOLD_LONG_MS * `CLK_KHZ),
	parameter logic [31:0] RESET_CYC = 32'(`RESET_PULSE_MS * `CLK_KHZ),
	parameter logic [31:0] EXTRA_CYC = 32'(`OFF_EXTRA_MS * `CLK_KHZ),
	parameter logic [31:0] STEP_CYC = 32'(`PULSE_STEP_US * `CLK_MHZ)
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic confirmKey,
	input wire logic cancelKey,
	input wire logic hostSense,
	input wire logic gpio1Sense,
	input wire logic watchdogBite,
	input wire logic pwrSwIn,
	output logic pwrSwOut,
	output logic pwrSwOe,
	input wire logic hostRstIn,
	output logic hostRstOut,
	output logic hostRstOe,
	output logic displayBlank,
	output logic selfRestart
);

	// Synchronised pin levels
	logic [5:0] pinSync;
	logic confirmS;
	logic cancelS;
	logic senseMainS;
	logic senseLegacyS;
	logic pwrPinS;
	logic rstPinS;
	// Key hold durations in cycles
	logic [31:0] confirmHold;
	logic [31:0] cancelHold;
	// Configuration, live and boot copy
	logic [7:0] cfg_q, cfg_d;
	logic [7:0] pulseWidth_q, pulseWidth_d;
	logic [7:0] bootCfg_q, bootCfg_d;
	logic [7:0] bootPulse_q, bootPulse_d;
	// Bus data-phase tracking
	logic wrPending_q, wrPending_d;
	logic [7:0] wrAddr_q, wrAddr_d;
	logic [31:0] rdData_q, rdData_d;
	// Sequencer state and its cycle timer
	atx_power_pkg::seq_state_t state_q, state_d;
	logic [31:0] timer_q, timer_d;
	logic restart_q, restart_d;
	// Idle pin levels learned for automatic polarity
	logic pwrIdle_q, pwrIdle_d;
	logic rstIdle_q, rstIdle_d;
	logic blank_q, blank_d;

	// Decoded controls
	logic hostUp;
	logic [31:0] pulseCyc;
	logic pwrLevel;
	logic rstLevel;
	logic addrPhase;

	// All pin inputs except watchdogBite pass two flops first
	sync_two_ff #(
		.WIDTH(6)
	) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.asyncIn({confirmKey, cancelKey, hostSense, gpio1Sense,
			pwrSwIn, hostRstIn}),
		.syncOut(pinSync)
	);

	assign {confirmS, cancelS, senseMainS, senseLegacyS,
		pwrPinS, rstPinS} = pinSync;

	// Hold timers, one per key
	key_hold_counter u_confirm_hold (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.keyDown(confirmS),
		.holdCount(confirmHold)
	);

	key_hold_counter u_cancel_hold (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.keyDown(cancelS),
		.holdCount(cancelHold)
	);

	assign hostUp = cfg_q[`CFG_LEGACY_SENSE_BIT] ? senseLegacyS
		: senseMainS;

	// So 16 steps is half second
	assign pulseCyc = 32'({24'h0, pulseWidth_q} * STEP_CYC);

	// Active drive level: opposite of idle level, or the invert bit
	assign pwrLevel = cfg_q[`CFG_AUTO_POL_BIT] ? ~pwrIdle_q
		: cfg_q[`CFG_PWR_INV_BIT];
	assign rstLevel = cfg_q[`CFG_AUTO_POL_BIT] ? ~rstIdle_q
		: cfg_q[`CFG_RST_INV_BIT];

	// Valid address phase seen by this slave
	assign addrPhase = hsel && hready && htrans[1];

	// Zero-wait slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdData_q;

	// Register file next values: bus writes, save, restart reload
	always_comb begin
		cfg_d = cfg_q;
		pulseWidth_d = pulseWidth_q;
		bootCfg_d = bootCfg_q;
		bootPulse_d = bootPulse_q;
		wrPending_d = addrPhase && hwrite;
		wrAddr_d = addrPhase ? haddr[7:0] : wrAddr_q;
		rdData_d = 32'h0;
		// Read data prepared in the address phase
		if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				`CFG_OFFSET: begin
					rdData_d = {24'h0, cfg_q};
				end
				`PULSE_OFFSET: begin
					rdData_d = {24'h0, pulseWidth_q};
				end
				`STATUS_OFFSET: begin
					rdData_d = {20'h0, state_q, rstPinS, pwrPinS,
						hostRstOe, pwrSwOe, blank_q, hostUp};
				end
				default: begin
					rdData_d = 32'h0;
				end
			endcase
		end
		// Writes land in the data phase
		if (wrPending_q) begin
			case (wrAddr_q)
				`CFG_OFFSET: begin
					cfg_d = hwdata[7:0];
				end
				`PULSE_OFFSET: begin
					pulseWidth_d = hwdata[7:0];
				end
				`CMD_OFFSET: begin
					if (hwdata[7:0] == `CMD_SAVE_BOOT) begin
						bootCfg_d = cfg_q;
						bootPulse_d = pulseWidth_q;
					end
				end
				default: begin
					cfg_d = cfg_q;
				end
			endcase
		end
		if (restart_q) begin
			cfg_d = bootCfg_q;
			pulseWidth_d = bootPulse_q;
		end
	end

	// Register file flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cfg_q <= `CFG_RESET;
			pulseWidth_q <= `PULSE_RESET;
			bootCfg_q <= `CFG_RESET;
			bootPulse_q <= `PULSE_RESET;
			wrPending_q <= 1'b0;
			wrAddr_q <= 8'h00;
			rdData_q <= 32'h0;
		end else begin
			cfg_q <= cfg_d;
			pulseWidth_q <= pulseWidth_d;
			bootCfg_q <= bootCfg_d;
			bootPulse_q <= bootPulse_d;
			wrPending_q <= wrPending_d;
			wrAddr_q <= wrAddr_d;
			rdData_q <= rdData_d;
		end
	end

	// Sequencer next state and timer
	always_comb begin
		state_d = state_q;
		timer_d = timer_q + 32'h1;
		restart_d = 1'b0;
		case (state_q)
			atx_power_pkg::ST_IDLE: begin
				timer_d = 32'h0;
				if (watchdogBite) begin
					state_d = atx_power_pkg::ST_RST_PULSE;
				end else if (cfg_q[`CFG_KEY_RESET_BIT] && hostUp
					&& confirmHold == HOLD_LONG_CYC) begin
					state_d = atx_power_pkg::ST_RST_PULSE;
				end else if (cfg_q[`CFG_KEY_ON_BIT] && !hostUp
					&& confirmHold == HOLD_SHORT_CYC) begin
					state_d = atx_power_pkg::ST_PWR_ON;
				end else if (cfg_q[`CFG_KEY_OFF_BIT] && hostUp
					&& cancelHold == HOLD_LONG_CYC) begin
					state_d = atx_power_pkg::ST_OFF_MIN;
				end
			end
			atx_power_pkg::ST_PWR_ON: begin
				if (timer_q >= pulseCyc) begin
					state_d = atx_power_pkg::ST_WAIT_REL;
					timer_d = 32'h0;
				end
			end
			atx_power_pkg::ST_OFF_MIN: begin
				if (timer_q >= pulseCyc) begin
					state_d = cancelS ? atx_power_pkg::ST_OFF_EXTRA
						: atx_power_pkg::ST_WAIT_REL;
					timer_d = 32'h0;
				end
			end
			atx_power_pkg::ST_OFF_EXTRA: begin
				if (!cancelS || timer_q >= EXTRA_CYC - 32'h1) begin
					state_d = atx_power_pkg::ST_WAIT_REL;
					timer_d = 32'h0;
				end
			end
			atx_power_pkg::ST_RST_PULSE: begin
				if (timer_q >= RESET_CYC - 32'h1) begin
					state_d = atx_power_pkg::ST_WAIT_REL;
					timer_d = 32'h0;
					restart_d = 1'b1;
				end
			end
			atx_power_pkg::ST_WAIT_REL: begin
				// Both keys up before next action
				timer_d = 32'h0;
				if (!confirmS && !cancelS) begin
					state_d = atx_power_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = atx_power_pkg::ST_IDLE;
				timer_d = 32'h0;
			end
		endcase
	end

	// Sequencer flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= atx_power_pkg::ST_IDLE;
			timer_q <= 32'h0;
			restart_q <= 1'b0;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			restart_q <= restart_d;
		end
	end

	// Pin drivers, idle level learning and display blanking
	always_comb begin
		pwrIdle_d = pwrSwOe ? pwrIdle_q : pwrPinS;
		rstIdle_d = hostRstOe ? rstIdle_q : rstPinS;
		blank_d = cfg_q[`CFG_BLANK_BIT] && !hostUp;
	end

	// Output flops
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pwrIdle_q <= 1'b1;
			rstIdle_q <= 1'b1;
			blank_q <= 1'b0;
			pwrSwOe <= 1'b0;
			pwrSwOut <= 1'b0;
			hostRstOe <= 1'b0;
			hostRstOut <= 1'b0;
		end else begin
			pwrIdle_q <= pwrIdle_d;
			rstIdle_q <= rstIdle_d;
			blank_q <= blank_d;
			// Power switch drives only in pulse
			pwrSwOe <= (state_d == atx_power_pkg::ST_PWR_ON)
				|| (state_d == atx_power_pkg::ST_OFF_MIN)
				|| (state_d == atx_power_pkg::ST_OFF_EXTRA);
			pwrSwOut <= pwrLevel;
			hostRstOe <= (state_d == atx_power_pkg::ST_RST_PULSE);
			hostRstOut <= rstLevel;
		end
	end

	assign displayBlank = blank_q;
	assign selfRestart = restart_q;

endmodule // atx_host_power_control
`default_nettype wire

// >>> include/atx_power_regs.svh
`ifndef ATX_POWER_REGS_SVH
`define ATX_POWER_REGS_SVH

// Register byte offsets on the AHB-Lite slave
`define CFG_OFFSET 8'h00
`define PULSE_OFFSET 8'h04
`define STATUS_OFFSET 8'h08
`define CMD_OFFSET 8'h0c

// Configuration byte field positions
`define CFG_AUTO_POL_BIT 0
`define CFG_RST_INV_BIT 1
`define CFG_PWR_INV_BIT 2
`define CFG_LEGACY_SENSE_BIT 3
`define CFG_KEY_RESET_BIT 4
`define CFG_KEY_OFF_BIT 5
`define CFG_KEY_ON_BIT 6
`define CFG_BLANK_BIT 7

// Reset values: all functions off, one-second pulse (32 steps)
`define CFG_RESET 8'h00
`define PULSE_RESET 8'h20

// Command code that stores the current setup as boot state
`define CMD_SAVE_BOOT 8'h04

// Timing figures in their own units
`define CLK_KHZ 200000
`define CLK_MHZ 200
`define HOLD_SHORT_MS 250
`define HOLD_LONG_MS 4000
`define RESET_PULSE_MS 1000
`define OFF_EXTRA_MS 5000
`define PULSE_STEP_US 31250

`endif

// >>> include/atx_power_pkg.sv
`default_nettype none
package atx_power_pkg;

	// Sequencer states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_PWR_ON = 6'b000010,
		ST_OFF_MIN = 6'b000100,
		ST_OFF_EXTRA = 6'b001000,
		ST_RST_PULSE = 6'b010000,
		ST_WAIT_REL = 6'b100000
	} seq_state_t;

endpackage
`default_nettype wire

// >>> design/sync_two_ff.sv
`default_nettype none
module sync_two_ff #(
	parameter int WIDTH = 6
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	// First stage, read only by the second stage
	logic [WIDTH-1:0] metaQ;

	// One two-flop chain per bit
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					metaQ[i] <= 1'b0;
					syncOut[i] <= 1'b0;
				end else begin
					metaQ[i] <= asyncIn[i];
					syncOut[i] <= metaQ[i];
				end
			end
		end
	endgenerate

endmodule // sync_two_ff
`default_nettype wire

// >>> design/key_hold_counter.sv
`default_nettype none
module key_hold_counter (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic keyDown,
	output logic [31:0] holdCount
);

	// Next hold count
	logic [31:0] holdCount_d;

	// Count cycles held, saturate, clear on release
	always_comb begin
		if (!keyDown) begin
			holdCount_d = 32'h0;
		end else if (holdCount == 32'hffffffff) begin
			holdCount_d = holdCount;
		end else begin
			holdCount_d = holdCount + 32'h1;
		end
	end

	// Register the count
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			holdCount <= 32'h0;
		end else begin
			holdCount <= holdCount_d;
		end
	end

endmodule // key_hold_counter
`default_nettype wire

// >>> test/atx_board_model.sv
`default_nettype none
module atx_board_model (
	input wire logic pwrSwOut,
	input wire logic pwrSwOe,
	input wire logic hostRstOut,
	input wire logic hostRstOe,
	output logic pwrSwIn,
	output logic hostRstIn
);
	timeunit 1ns;
	timeprecision 1ps;
	assign pwrSwIn = pwrSwOe ? pwrSwOut : 1'b1;
	assign hostRstIn = hostRstOe ? hostRstOut : 1'b1;
endmodule // atx_board_model
`default_nettype wire

// >>> test/atx_power_checker.sv
`default_nettype none
module atx_power_checker #(
	parameter logic [31:0] RESET_CYC = 32'h1e
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic confirmKey,
	input wire logic cancelKey,
	input wire logic hostSense,
	input wire logic gpio1Sense,
	input wire logic pwrSwOut,
	input wire logic pwrSwOe,
	input wire logic hostRstOut,
	input wire logic hostRstOe,
	input wire logic displayBlank,
	input wire logic selfRestart
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cycles the reset pin has been driven
	logic [31:0] rstLen_q, rstLen_d;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);
	// Count while driving, clear when released
	always_comb begin
		rstLen_d = hostRstOe ? rstLen_q + 32'h1 : 32'h0;
	end
	// Length register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstLen_q <= 32'h0;
		end else begin
			rstLen_q <= rstLen_d;
		end
	end
	// A key was down before the drive began
	sequence keyEarlier;
		$past(confirmKey, 4) || $past(cancelKey, 4);
	endsequence
	// Host seen up on both sense inputs
	sequence hostUp;
		(hostSense && gpio1Sense) [*6];
	endsequence
	pwr_cause_a: assert property ($rose(pwrSwOe) |-> keyEarlier)
		else $error("power drive without key");
	pwr_steady_a: assert property (pwrSwOe && $past(pwrSwOe) |->
		$stable(pwrSwOut)) else $error("power level moved");
	rst_steady_a: assert property (hostRstOe && $past(hostRstOe) |->
		$stable(hostRstOut)) else $error("reset level moved");
	one_drive_a: assert property (!(pwrSwOe && hostRstOe))
		else $error("both pins driven");
	rst_width_a: assert property ($fell(hostRstOe) |->
		rstLen_q == RESET_CYC) else $error("reset width wrong");
	restart_follow_a: assert property ($fell(hostRstOe) |->
		##[0:1] selfRestart) else $error("no restart");
	restart_single_a: assert property (selfRestart |=> !selfRestart)
		else $error("restart too long");
	blank_up_a: assert property (hostUp |=> !displayBlank)
		else $error("blank while host up");
endmodule // atx_power_checker
bind atx_host_power_control atx_power_checker #(.RESET_CYC(RESET_CYC))
	atx_power_checker_i (.sys_clk, .resetn, .confirmKey, .cancelKey,
	.hostSense, .gpio1Sense, .pwrSwOut, .pwrSwOe, .hostRstOut, .hostRstOe,
	.displayBlank, .selfRestart);
`default_nettype wire

// >>> test/atx_host_power_control_test.sv
`default_nettype none
`include "atx_power_regs.svh"
`define CHK(a, e) begin \
	num_checks++; \
	if ((a) !== (e)) begin \
		mismatches++; \
		$display("[FAIL] %0t got %h exp %h", $time, a, e); \
	end \
end
module atx_host_power_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	// Short counts for simulation
	localparam logic [31:0] STEP = 32'h2;
	localparam logic [31:0] RST = 32'h1e;
	localparam logic [31:0] EXTRA = 32'h28;
	logic sys_clk, resetn, hsel, hwrite, hready, hreadyout, hresp;
	logic confirmKey, cancelKey, hostSense, gpio1Sense, watchdogBite;
	logic pwrSwIn, pwrSwOut, pwrSwOe, hostRstIn, hostRstOut, hostRstOe;
	logic displayBlank, selfRestart, lvl, sawRestart;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd, rdHold, pw, rw, pl;
	int mismatches, num_checks, cyc;
	// Single slave: its ready is the bus ready
	assign hready = hreadyout;
	atx_host_power_control #(.HOLD_SHORT_CYC(32'h14),
		.HOLD_LONG_CYC(32'h3c), .RESET_CYC(RST), .EXTRA_CYC(EXTRA),
		.STEP_CYC(STEP)) atx_host_power_control_i (.sys_clk, .resetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .confirmKey, .cancelKey, .hostSense,
		.gpio1Sense, .watchdogBite, .pwrSwIn, .pwrSwOut, .pwrSwOe,
		.hostRstIn, .hostRstOut, .hostRstOe, .displayBlank, .selfRestart);
	atx_board_model atx_board_model_i (.pwrSwOut, .pwrSwOe, .hostRstOut,
		.hostRstOe, .pwrSwIn, .hostRstIn);
	// Clock, 5 ns period
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Edge samples of read data and restart; hang guard
	always @(posedge sys_clk) begin
		rdHold <= hrdata;
		if (selfRestart === 1'b1) sawRestart <= 1'b1;
		cyc++;
		if (cyc > 30000) begin
			mismatches++;
			report_and_stop();
		end
	end
	// Counts and verdict
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// One single word transfer
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (hready !== 1'b1) @(posedge sys_clk);
		@(negedge sys_clk);
		rd = rdHold;
		`CHK(hresp, 1'b0)
	endtask
	// Hold keys, measure drive widths, then release
	task automatic press(input logic c, input logic x);
		int n;
		n = 0;
		pw = 32'h0;
		rw = 32'h0;
		@(posedge sys_clk);
		confirmKey <= c;
		cancelKey <= x;
		watchdogBite <= 1'b0;
		@(negedge sys_clk);
		while (pwrSwOe !== 1'b1 && hostRstOe !== 1'b1 && n < 200) begin
			n++;
			@(negedge sys_clk);
		end
		lvl = pwrSwOut;
		while (pwrSwOe === 1'b1 || hostRstOe === 1'b1) begin
			pw += pwrSwOe;
			rw += hostRstOe;
			@(negedge sys_clk);
		end
		@(posedge sys_clk);
		confirmKey <= 1'b0;
		cancelKey <= 1'b0;
		repeat (8) @(posedge sys_clk);
	endtask
	// Main sequence
	initial begin
		resetn = 1'b0;
		{hsel, hwrite, confirmKey, cancelKey, watchdogBite} = 5'h0;
		{hostSense, gpio1Sense, sawRestart, htrans} = 5'h0;
		{haddr, hwdata} = 64'h0;
		void'($urandom(32'h1d73));
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		// Reset contents and an unmapped word
		ahb(1'b1, 8'h10, 32'hff);
		ahb(1'b0, 8'h10, 32'h0);
		`CHK(rd, 32'h0)
		ahb(1'b0, `CFG_OFFSET, 32'h0);
		`CHK(rd, 32'h0)
		ahb(1'b0, `PULSE_OFFSET, 32'h0);
		`CHK(rd, 32'h20)
		ahb(1'b0, `STATUS_OFFSET, 32'h0);
		`CHK(rd, 32'h70)
		$display("register test done");
		// Power on, half second first, then random widths
		for (int i = 0; i < 3; i++) begin
			pl = (i == 0) ? 32'h10 : 32'h1 + ($urandom % 32'hf);
			ahb(1'b1, `PULSE_OFFSET, pl);
			ahb(1'b1, `CFG_OFFSET, 32'hf1);
			press(1'b1, 1'b0);
			`CHK(pw, pl * STEP + 32'h1)
			`CHK(lvl, 1'b0)
			`CHK(displayBlank, 1'b1)
		end
		// Legacy sense input with fixed inverted drive
		hostSense <= 1'b1;
		ahb(1'b1, `CFG_OFFSET, 32'h4c);
		press(1'b1, 1'b0);
		`CHK(pw, pl * STEP + 32'h1)
		`CHK(lvl, 1'b1)
		// All functions disabled
		gpio1Sense <= 1'b1;
		ahb(1'b1, `CFG_OFFSET, 32'h0);
		press(1'b1, 1'b0);
		`CHK(pw, 32'h0)
		$display("power on test done");
		// Hard off, key held past the minimum
		ahb(1'b1, `CFG_OFFSET, 32'hf1);
		ahb(1'b1, `PULSE_OFFSET, 32'h4);
		press(1'b0, 1'b1);
		`CHK(pw >= 32'h9, 1'b1)
		`CHK(pw <= 32'h9 + EXTRA, 1'b1)
		`CHK(displayBlank, 1'b0)
		$display("power off test done");
		// Save boot copy, change setup, hard reset reloads
		ahb(1'b1, `CMD_OFFSET, 32'h4);
		ahb(1'b1, `CFG_OFFSET, 32'h10);
		press(1'b1, 1'b0);
		`CHK(rw, RST)
		`CHK(sawRestart, 1'b1)
		ahb(1'b0, `CFG_OFFSET, 32'h0);
		`CHK(rd, 32'hf1)
		// Watchdog bite from idle; press lowers it at the sampling edge
		@(posedge sys_clk);
		watchdogBite <= 1'b1;
		press(1'b0, 1'b0);
		`CHK(rw, RST)
		$display("reset test done");
		report_and_stop();
	end
endmodule // atx_host_power_control_test
`default_nettype wire
